// ===== eid_core.v
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "eid_map.vh"
// Behaviour
// - Transmit machine fault sets flag bit 7; software then resets the transmitter.
// - PHY management read or write completion sets flag bit 6.
// - While receive overrun flag bit 2 is set, incoming packets are discarded.
// - Control frame transmission finished sets flag bit 1.
// - Packet transmission finished sets flag bit 0.
// - Control frame reception finished sets flag bit 5.
// - Pause frame reception finished sets flag bit 4.
// - Received frame completely stored sets flag bit 3.
// - Three pointers bound transmit region and receive region in shared memory.
// - Packet buffers are 32, 64, 128 or 256 bytes, selected by bits 7:6.
// - Descriptor precedes frame data; a packet may span consecutive buffers.
// - Descriptor is seven bytes: 24-bit next pointer, size, 16-bit status.
// - Size counts data bytes with four CRC bytes, not descriptor bytes.
// - Status bit 15 is ownership: zero host, one MAC.
// - Status bit 14 marks aborted packet, bit 13 back pressure applied.
// - Status bit 12 set when size exceeds maximum frame length.
// - Bit 11 for type/length above 1518; bit 10 for length mismatch.
// - Bit 9 when automatic FCS is off and final four bytes are bad.
// - Bit 8 on deferral; bit 7 on excessive deferral beyond limits.
// - Bit 6 on FIFO underrun; abort bit says dropped or retried.
// - Collision past the six-bit window is late, bit 5; earlier ones retry.
// - Collisions beyond retry limit abort with bit 4; count in bits 3:0.
// - Finished packet gets status written back with ownership cleared.
module eid_core (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire tx_fault_evt,
    input wire mgmt_done_evt,
    input wire rx_overrun_evt,
    input wire rx_cf_evt,
    input wire rx_pcf_evt,
    input wire rx_stored_evt,
    input wire [23:0] rx_pkt_start,
    input wire [15:0] rx_pkt_size,
    input wire tx_end,
    input wire tx_ctrl_frame,
    input wire [23:0] tx_desc_addr,
    input wire [15:0] tx_pkt_size,
    input wire [15:0] tx_type_len,
    input wire [15:0] tx_data_len,
    input wire tx_fcs_ok,
    input wire tx_bp_applied,
    input wire tx_deferred,
    input wire [15:0] tx_defer_time,
    input wire tx_speed_100,
    input wire tx_underrun,
    input wire tx_underrun_retry,
    input wire tx_collided,
    input wire [15:0] tx_col_byte,
    input wire [4:0] tx_col_count,
    output wire tx_retry,
    output wire tx_reset,
    output wire wb_valid,
    input wire wb_ready,
    output wire [23:0] wb_addr,
    output wire [15:0] wb_data,
    output wire rx_discard,
    output wire [23:0] rx_next_ptr,
    output wire rx_next_valid,
    output wire [8:0] buf_bytes,
    output wire irq
);

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_WB = 2'b10;

    reg [7:0] flags_q, flags_d;
    reg [23:0] tx_start_q, rx_start_q, rx_end_q;
    reg [7:0] buf_size_q;
    reg [8:0] buf_bytes_q;
    reg [15:0] max_frame_q;
    reg [5:0] col_win_q;
    reg [3:0] retry_q;
    reg auto_fcs_q;
    reg tx_reset_q;
    reg aw_held_q, w_held_q, bvalid_q, rvalid_q;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg [1:0] bresp_q, rresp_q;
    reg [31:0] rdata_q;
    reg [1:0] state_q;
    reg [15:0] stat_q;
    reg [23:0] wb_addr_q;
    reg ctrl_frame_q;
    reg tx_retry_q;
    reg [23:0] rx_next_q;
    reg rx_next_vld_q;
    reg [31:0] rd_mux;
    reg rd_hit;
    reg wr_hit;
    reg [15:0] stat_d;
    reg abort_c, retry_c, maxcol_c, late_c;

    wire wr_fire = aw_held_q & w_held_q;
    wire wb_done = (state_q == ST_WB) & wb_ready;
    wire rd_take = s_axi_arvalid & ~rvalid_q;

    // Byte-lane merge under write strobes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] din;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = din[i*8 +: 8];
                end
            end
        end
    endfunction

    // Start of the packet after this one, wrapped inside its region
    function [23:0] next_ptr;
        input [23:0] start;
        input [15:0] size;
        input [1:0] sel;
        input [23:0] lo;
        input [23:0] hi;
        reg [24:0] span;
        reg [24:0] mask;
        reg [24:0] sum;
        begin
            mask = {17'h0_0000, 8'hFF} >> sel;
            span = {9'h000, size} + {9'h000, `EID_DESC_BYTES} + mask;
            span = span & ~mask;
            sum = {1'b0, start} + span;
            if (sum >= {1'b0, hi}) begin
                sum = sum - ({1'b0, hi} - {1'b0, lo});
            end
            next_ptr = sum[23:0];
        end
    endfunction

    // Strobe-merged words; only the low bytes land in the narrower registers
    wire [31:0] tx_start_m = merge({8'h00, tx_start_q}, w_data_q, w_strb_q);
    wire [31:0] rx_start_m = merge({8'h00, rx_start_q}, w_data_q, w_strb_q);
    wire [31:0] rx_end_m = merge({8'h00, rx_end_q}, w_data_q, w_strb_q);
    wire [31:0] max_frame_m = merge({16'h0000, max_frame_q}, w_data_q, w_strb_q);

    // AXI handshakes; one write and one read in flight at a time
    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready = ~w_held_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    assign tx_retry = tx_retry_q;
    assign tx_reset = tx_reset_q;
    assign wb_valid = (state_q == ST_WB);
    assign wb_addr = wb_addr_q;
    assign wb_data = stat_q;
    assign rx_discard = flags_q[`EID_FLG_RX_OVR];
    assign rx_next_ptr = rx_next_q;
    assign rx_next_valid = rx_next_vld_q;
    assign buf_bytes = buf_bytes_q;
    assign irq = |flags_q;

    // Transmit outcome decode into the status word
    always @* begin
        late_c = tx_collided & (tx_col_byte > {10'h000, col_win_q});
        maxcol_c = tx_collided & (tx_col_count > {1'b0, retry_q});
        abort_c = maxcol_c | (tx_underrun & ~tx_underrun_retry);
        retry_c = ~abort_c & ((tx_collided & ~late_c) | tx_underrun);
        stat_d = 16'h0000;
        stat_d[`EID_TS_OWNER] = 1'b0;
        stat_d[`EID_TS_ABORT] = abort_c;
        stat_d[`EID_TS_BP] = tx_bp_applied;
        stat_d[`EID_TS_HUGE] = tx_pkt_size > max_frame_q;
        stat_d[`EID_TS_LOOR] = tx_type_len > `EID_LEN_LIMIT;
        stat_d[`EID_TS_LCERR] = (tx_type_len <= `EID_LEN_LIMIT) &
            (tx_type_len != tx_data_len);
        stat_d[`EID_TS_CRCERR] = ~auto_fcs_q & ~tx_fcs_ok;
        stat_d[`EID_TS_DEFER] = tx_deferred;
        stat_d[`EID_TS_XSDEFER] = tx_speed_100 ? (tx_defer_time > `EID_XSDEF_NIB) :
            (tx_defer_time > `EID_XSDEF_BIT);
        stat_d[`EID_TS_UNDER] = tx_underrun;
        stat_d[`EID_TS_LATE] = late_c;
        stat_d[`EID_TS_MAXCOL] = maxcol_c;
        stat_d[3:0] = tx_col_count[4] ? 4'hF : tx_col_count[3:0];
    end

    // Write-back machine; a retried packet never returns to the host
    always @(posedge aclk) begin
        if (!aresetn || tx_reset_q) begin
            state_q <= ST_IDLE;
            stat_q <= 16'h0000;
            wb_addr_q <= 24'h00_0000;
            ctrl_frame_q <= 1'b0;
            tx_retry_q <= 1'b0;
        end else begin
            tx_retry_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (tx_end && retry_c) begin
                        tx_retry_q <= 1'b1;
                    end else if (tx_end) begin
                        stat_q <= stat_d;
                        wb_addr_q <= tx_desc_addr + `EID_DESC_STAT_OFS;
                        ctrl_frame_q <= tx_ctrl_frame;
                        state_q <= ST_WB;
                    end
                end
                ST_WB: begin
                    if (wb_ready) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Sticky flags; a set in the clearing cycle wins
    always @* begin
        flags_d = flags_q;
        if (wr_fire && aw_addr_q == `EID_OFS_FLAGS && w_strb_q[0]) begin
            flags_d = flags_q & ~w_data_q[7:0];
        end
        if (tx_fault_evt) flags_d[`EID_FLG_TX_FAULT] = 1'b1;
        if (mgmt_done_evt) flags_d[`EID_FLG_MGMT] = 1'b1;
        if (rx_overrun_evt) flags_d[`EID_FLG_RX_OVR] = 1'b1;
        if (rx_cf_evt && !rx_discard) flags_d[`EID_FLG_RX_CF] = 1'b1;
        if (rx_pcf_evt && !rx_discard) flags_d[`EID_FLG_RX_PCF] = 1'b1;
        if (rx_stored_evt && !rx_discard) flags_d[`EID_FLG_RX_DONE] = 1'b1;
        if (wb_done && ctrl_frame_q) flags_d[`EID_FLG_TX_CF] = 1'b1;
        if (wb_done) flags_d[`EID_FLG_TX_DONE] = 1'b1;
    end

    // Receive next-pointer, reported once the frame is stored
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_next_q <= `EID_RST_PTR;
            rx_next_vld_q <= 1'b0;
        end else begin
            rx_next_vld_q <= rx_stored_evt & ~rx_discard;
            if (rx_stored_evt && !rx_discard) begin
                rx_next_q <= next_ptr(rx_pkt_start, rx_pkt_size,
                    buf_size_q[`EID_BSZ_HI:`EID_BSZ_LO], rx_start_q, rx_end_q);
            end
        end
    end

    // Write address decode
    always @* begin
        case (aw_addr_q)
            `EID_OFS_FLAGS, `EID_OFS_TX_START, `EID_OFS_RX_START, `EID_OFS_RX_END,
            `EID_OFS_BUF_SIZE, `EID_OFS_MAX_FRAME, `EID_OFS_COL_WIN,
            `EID_OFS_RETRY, `EID_OFS_CTRL, `EID_OFS_TX_STAT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Bus write side and software registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            flags_q <= 8'h00;
            tx_start_q <= `EID_RST_PTR;
            rx_start_q <= `EID_RST_PTR;
            rx_end_q <= `EID_RST_PTR;
            buf_size_q <= `EID_RST_BUF_SIZE;
            buf_bytes_q <= `EID_BUF_MAX_BYTES; // Code 00 selects the largest buffer
            max_frame_q <= `EID_RST_MAX_FRAME;
            col_win_q <= `EID_RST_COL_WIN;
            retry_q <= `EID_RST_RETRY;
            auto_fcs_q <= |(`EID_RST_CTRL & 2'h1);
            tx_reset_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            tx_reset_q <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? 2'b00 : 2'b10;
                case (aw_addr_q)
                    `EID_OFS_TX_START:
                        tx_start_q <= tx_start_m[23:0];
                    `EID_OFS_RX_START:
                        rx_start_q <= rx_start_m[23:0];
                    `EID_OFS_RX_END:
                        rx_end_q <= rx_end_m[23:0];
                    `EID_OFS_BUF_SIZE:
                        if (w_strb_q[0]) begin
                            buf_size_q <= w_data_q[7:0];
                            buf_bytes_q <= `EID_BUF_MAX_BYTES >>
                                w_data_q[`EID_BSZ_HI:`EID_BSZ_LO];
                        end
                    `EID_OFS_MAX_FRAME:
                        max_frame_q <= max_frame_m[15:0];
                    `EID_OFS_COL_WIN:
                        if (w_strb_q[0]) col_win_q <= w_data_q[5:0];
                    `EID_OFS_RETRY:
                        if (w_strb_q[0]) retry_q <= w_data_q[3:0];
                    `EID_OFS_CTRL:
                        if (w_strb_q[0]) begin
                            auto_fcs_q <= w_data_q[`EID_CTL_FCS];
                            tx_reset_q <= w_data_q[`EID_CTL_TXRST];
                        end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read data mux; unmapped reads answer SLVERR with zero data
    always @* begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case ({s_axi_araddr[7:2], 2'b00})
            `EID_OFS_FLAGS: rd_mux = {24'h00_0000, flags_q};
            `EID_OFS_TX_START: rd_mux = {8'h00, tx_start_q};
            `EID_OFS_RX_START: rd_mux = {8'h00, rx_start_q};
            `EID_OFS_RX_END: rd_mux = {8'h00, rx_end_q};
            `EID_OFS_BUF_SIZE: rd_mux = {24'h00_0000, buf_size_q};
            `EID_OFS_MAX_FRAME: rd_mux = {16'h0000, max_frame_q};
            `EID_OFS_COL_WIN: rd_mux = {26'h000_0000, col_win_q};
            `EID_OFS_RETRY: rd_mux = {28'h000_0000, retry_q};
            `EID_OFS_CTRL: rd_mux = {31'h0000_0000, auto_fcs_q};
            `EID_OFS_TX_STAT: rd_mux = {16'h0000, stat_q};
            default: rd_hit = 1'b0;
        endcase
    end

    // Bus read side; reads never disturb the flags
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'b00;
        end else begin
            if (rd_take) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_hit ? 2'b00 : 2'b10;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

endmodule

// ===== eid_map.vh
`ifndef EID_MAP_VH
`define EID_MAP_VH
// Register byte offsets on the AXI4-Lite bus
`define EID_OFS_FLAGS 8'h00
`define EID_OFS_TX_START 8'h04
`define EID_OFS_RX_START 8'h08
`define EID_OFS_RX_END 8'h0C
`define EID_OFS_BUF_SIZE 8'h10
`define EID_OFS_MAX_FRAME 8'h14
`define EID_OFS_COL_WIN 8'h18
`define EID_OFS_RETRY 8'h1C
`define EID_OFS_CTRL 8'h20
`define EID_OFS_TX_STAT 8'h24
// Event flag bit positions
`define EID_FLG_TX_FAULT 7
`define EID_FLG_MGMT 6
`define EID_FLG_RX_CF 5
`define EID_FLG_RX_PCF 4
`define EID_FLG_RX_DONE 3
`define EID_FLG_RX_OVR 2
`define EID_FLG_TX_CF 1
`define EID_FLG_TX_DONE 0
// Transmit status word bit positions
`define EID_TS_OWNER 15
`define EID_TS_ABORT 14
`define EID_TS_BP 13
`define EID_TS_HUGE 12
`define EID_TS_LOOR 11
`define EID_TS_LCERR 10
`define EID_TS_CRCERR 9
`define EID_TS_DEFER 8
`define EID_TS_XSDEFER 7
`define EID_TS_UNDER 6
`define EID_TS_LATE 5
`define EID_TS_MAXCOL 4
// Control register fields
`define EID_CTL_FCS 0
`define EID_CTL_TXRST 1
// Buffer size select field, bits 7:6
`define EID_BSZ_HI 7
`define EID_BSZ_LO 6
// Descriptor layout and limits
`define EID_DESC_BYTES 16'h0007
`define EID_DESC_STAT_OFS 24'h00_0005
`define EID_LEN_LIMIT 16'h05EE
`define EID_XSDEF_NIB 16'h17B7
`define EID_XSDEF_BIT 16'h5EDF
// Reset values
`define EID_RST_PTR 24'h00_0000
`define EID_RST_BUF_SIZE 8'h00
`define EID_BUF_MAX_BYTES 9'h100
`define EID_RST_MAX_FRAME 16'h05EE
`define EID_RST_COL_WIN 6'h38
`define EID_RST_RETRY 4'hF
`define EID_RST_CTRL 2'h1
`endif

// ===== eid_wb_model.sv
`timescale 1ns/1ns
module eid_wb_model (
    input wire aclk,
    input wire aresetn,
    input wire wb_valid,
    input wire [3:0] delay,
    output wire wb_ready
);
    reg [3:0] cnt_q;
    reg rdy_q;
    assign wb_ready = rdy_q;
    // Memory side stalls, then takes one status word and returns the packet to the host
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 4'h0;
            rdy_q <= 1'h0;
        end else if (wb_valid && !rdy_q && cnt_q < delay) begin
            cnt_q <= cnt_q + 4'h1;
        end else if (wb_valid && !rdy_q) begin
            rdy_q <= 1'h1;
        end else begin
            rdy_q <= 1'h0;
            cnt_q <= 4'h0;
        end
    end
endmodule

// ===== eid_core_sva.sv
`timescale 1ns/1ns
module eid_core_sva (
    input wire aclk,
    input wire aresetn,
    input wire tx_fault_evt,
    input wire rx_overrun_evt,
    input wire rx_stored_evt,
    input wire tx_end,
    input wire [23:0] tx_desc_addr,
    input wire tx_bp_applied,
    input wire tx_deferred,
    input wire tx_underrun,
    input wire tx_underrun_retry,
    input wire tx_collided,
    input wire [4:0] tx_col_count,
    input wire tx_retry,
    input wire tx_reset,
    input wire wb_valid,
    input wire wb_ready,
    input wire [23:0] wb_addr,
    input wire [15:0] wb_data,
    input wire rx_discard,
    input wire rx_next_valid,
    input wire [8:0] buf_bytes,
    input wire irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A fault shows on the request line one cycle later
    a_fault_sets_irq: assert property (tx_fault_evt |=> irq) else $error("fault no irq");
    a_reset_one_pulse: assert property (tx_reset |=> !tx_reset) else $error("reset pulse");
    a_overrun_discard: assert property (rx_overrun_evt |=> rx_discard && irq) else $error("ovr");
    a_discard_no_store: assert property (rx_discard && rx_stored_evt |=> !rx_next_valid)
        else $error("stored while discarding");
    a_done_sets_irq: assert property (wb_valid && wb_ready |=> irq && !wb_valid)
        else $error("done flag");
    a_retry_underrun: assert property (tx_end && !wb_valid && tx_underrun
        && tx_underrun_retry && !tx_collided |=> tx_retry && !wb_valid) else $error("no retry");
    a_wb_after_end: assert property (tx_end && !wb_valid && !tx_underrun && !tx_collided
        |=> wb_valid && !tx_retry && wb_addr == $past(tx_desc_addr) + 24'h00_0005)
        else $error("write-back");
    a_owner_cleared: assert property (wb_valid |-> !wb_data[15]) else $error("owner");
    a_wb_holds: assert property (wb_valid && !wb_ready |=> wb_valid && $stable(wb_data)
        && $stable(wb_addr)) else $error("wb hold");
    a_status_copy: assert property ($rose(wb_valid)
        |-> wb_data[13] == $past(tx_bp_applied)
        && wb_data[8] == $past(tx_deferred) && wb_data[6] == $past(tx_underrun))
        else $error("status bits");
    a_clash_count: assert property ($rose(wb_valid) |-> {1'h0, wb_data[3:0]} ==
        (($past(tx_col_count) > 5'h0F) ? 5'h0F : $past(tx_col_count)))
        else $error("clash count");
    a_buf_legal: assert property (buf_bytes == 9'h020 || buf_bytes == 9'h040
        || buf_bytes == 9'h080 || buf_bytes == 9'h100) else $error("buf size");
endmodule
bind eid_core eid_core_sva u_sva (.*);

// ===== tb_emac_interrupt_descriptor_status.sv
`timescale 1ns/1ns
`include "eid_map.vh"
module tb_emac_interrupt_descriptor_status;
    reg aclk = 0, aresetn = 0;
    reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    reg [31:0] s_axi_wdata = 0;
    reg [3:0] s_axi_wstrb = 4'hF;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    reg tx_fault_evt = 0, mgmt_done_evt = 0, rx_overrun_evt = 0;
    reg rx_cf_evt = 0, rx_pcf_evt = 0, rx_stored_evt = 0;
    reg [23:0] rx_pkt_start = 0, tx_desc_addr = 24'h12_3450;
    reg [15:0] rx_pkt_size = 0, tx_pkt_size = 0, tx_type_len = 0, tx_data_len = 0;
    reg [15:0] tx_defer_time = 0, tx_col_byte = 0;
    reg tx_end = 0, tx_ctrl_frame = 0, tx_fcs_ok = 0, tx_bp_applied = 0, tx_deferred = 0;
    reg tx_speed_100 = 0, tx_underrun = 0, tx_underrun_retry = 0, tx_collided = 0;
    reg [4:0] tx_col_count = 0;
    wire tx_retry, tx_reset, wb_valid, wb_ready, rx_discard, rx_next_valid, irq;
    wire [23:0] wb_addr, rx_next_ptr;
    wire [15:0] wb_data;
    wire [8:0] buf_bytes;
    reg [3:0] wb_delay = 0;
    integer fail_count = 0, n_compared = 0, i, n_rst = 0;
    reg [31:0] rd;
    reg [1:0] rr;
    // Flag bit raised by each event input, highest index first
    localparam [23:0] FB = {4'h3, 4'h4, 4'h5, 4'h2, 4'h6, 4'h7};

    eid_core u_dut (.*);
    eid_wb_model u_wb (.aclk(aclk), .aresetn(aresetn), .wb_valid(wb_valid),
        .delay(wb_delay), .wb_ready(wb_ready));

    // 10 MHz clock
    initial forever #50 aclk = ~aclk;
    // Count transmitter reset pulses
    always @(posedge aclk) if (tx_reset) n_rst <= n_rst + 1;

    task chk(input [8*8:1] nm, input [31:0] s, input [31:0] e);
        begin
            n_compared = n_compared + 1;
            if (s !== e) begin
                fail_count = fail_count + 1;
                $display("mismatch %0s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    // Address and data offered together, each dropped once taken
    task axw(input [7:0] a, input [31:0] d);
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
            do begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'h0;
                if (s_axi_wready) s_axi_wvalid <= 1'h0;
            end while (!s_axi_bvalid);
            rr = s_axi_bresp;
            s_axi_bready <= 1'h0;
        end
    endtask
    task axr(input [7:0] a);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
            do begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'h0;
            end while (!s_axi_rvalid);
            rd = s_axi_rdata;
            rr = s_axi_rresp;
            s_axi_rready <= 1'h0;
        end
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        begin
            axr(a);
            chk("reg", rd, e);
        end
    endtask
    // One-cycle event pulses: {stored, pause, ctrl, overrun, mgmt, fault}
    task pulse(input [5:0] m);
        begin
            @(posedge aclk);
            {rx_stored_evt, rx_pcf_evt, rx_cf_evt, rx_overrun_evt, mgmt_done_evt, tx_fault_evt} <= m;
            @(posedge aclk);
            {rx_stored_evt, rx_pcf_evt, rx_cf_evt, rx_overrun_evt, mgmt_done_evt, tx_fault_evt} <= 0;
        end
    endtask
    task rxs(input [23:0] st, input [15:0] sz, input [23:0] e);
        begin
            rx_pkt_start <= st;
            rx_pkt_size <= sz;
            pulse(6'h20);
            @(posedge aclk);
            chk("nxtv", rx_next_valid, 1);
            chk("nxtp", rx_next_ptr, e);
        end
    endtask
    // Outcome f: {ctrl, fcs_ok, bp, defer, 100M, underrun, ur_retry, collided}; e FFFF = retry
    task txc(input [7:0] f, input [15:0] s, t, l, d, b, input [4:0] c, input [15:0] e);
        begin
            @(posedge aclk);
            {tx_ctrl_frame, tx_fcs_ok, tx_bp_applied, tx_deferred, tx_speed_100, tx_underrun,
                tx_underrun_retry, tx_collided} <= f;
            tx_pkt_size <= s;
            tx_type_len <= t;
            tx_data_len <= l;
            tx_defer_time <= d;
            tx_col_byte <= b;
            tx_col_count <= c;
            tx_desc_addr <= tx_desc_addr + 24'h00_0100;
            wb_delay <= wb_delay + 4'h3;
            tx_end <= 1'h1;
            @(posedge aclk);
            tx_end <= 1'h0;
            @(posedge aclk);
            if (e === 16'hFFFF) begin
                chk("retry", tx_retry, 1);
                chk("wbv", wb_valid, 0);
                rchk(`EID_OFS_FLAGS, 0);
            end else begin
                while (!(wb_valid && wb_ready)) @(posedge aclk);
                chk("wbaddr", wb_addr, tx_desc_addr + 24'h00_0005);
                chk("wbdata", wb_data, e);
                rchk(`EID_OFS_FLAGS, {f[7], 1'h1});
                rchk(`EID_OFS_TX_STAT, e);
                axw(`EID_OFS_FLAGS, 32'h0000_00FF);
            end
        end
    endtask
    task complete_run;
        begin
            $display("comparisons %0d mismatches %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count = fail_count + 1;
        complete_run;
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        chk("bufb", buf_bytes, 32'h0000_0100);
        rchk(`EID_OFS_MAX_FRAME, 32'h0000_05EE);
        rchk(`EID_OFS_COL_WIN, 32'h0000_0038);
        rchk(`EID_OFS_RETRY, 32'h0000_000F);
        rchk(`EID_OFS_FLAGS, 0);
        axr(8'h30);
        chk("rresp", rr, 2'h2);
        axw(8'h30, 32'h0000_0001);
        chk("bresp", rr, 2'h2);
        axw(`EID_OFS_RX_START, 32'h0000_0100);
        axw(`EID_OFS_RX_END, 32'h0000_0400);
        rchk(`EID_OFS_RX_END, 32'h0000_0400);
        axw(`EID_OFS_TX_START, 32'h0000_0040);
        rchk(`EID_OFS_TX_START, 32'h0000_0040);
        for (i = 0; i < 4; i = i + 1) begin
            axw(`EID_OFS_BUF_SIZE, i << 6);
            chk("bufb", buf_bytes, 32'h0000_0100 >> i);
        end
        // Each event flag stays until written back as one
        for (i = 0; i < 6; i = i + 1) begin
            pulse(6'h01 << i);
            rchk(`EID_OFS_FLAGS, 32'h1 << FB[i*4+:4]);
            chk("irq", irq, 1);
            axw(`EID_OFS_FLAGS, 32'h0000_00FF);
            @(posedge aclk);
            chk("irq", irq, 0);
        end
        pulse(6'h04);
        pulse(6'h38);
        @(posedge aclk);
        chk("nxtv", rx_next_valid, 0);
        chk("disc", rx_discard, 1);
        rchk(`EID_OFS_FLAGS, 32'h0000_0004);
        axw(`EID_OFS_FLAGS, 32'h0000_0004);
        @(posedge aclk);
        chk("disc", rx_discard, 0);
        rxs(24'h00_0100, 16'h0019, 24'h00_0120);
        rxs(24'h00_0100, 16'h001A, 24'h00_0140);
        axw(`EID_OFS_BUF_SIZE, 0);
        rxs(24'h00_0100, 16'h003C, 24'h00_0200);
        rxs(24'h00_0300, 16'h00FA, 24'h00_0200);
        axw(`EID_OFS_FLAGS, 32'h0000_00FF);
        txc(8'hF8, 16'h0040, 16'h002E, 16'h002E, 16'h17B8, 0, 0, 16'h2180);
        txc(8'h41, 16'h05EF, 16'h05EF, 0, 0, 16'h0039, 5'h03, 16'h1823);
        axw(`EID_OFS_CTRL, 0);
        txc(8'h10, 16'h0064, 16'h0064, 16'h005A, 16'h5EE0, 0, 0, 16'h0780);
        axw(`EID_OFS_CTRL, 32'h0000_0001);
        txc(8'h58, 16'h05EE, 16'h05EE, 16'h05EE, 16'h17B7, 0, 0, 16'h0100);
        txc(8'h41, 16'h0040, 16'h002E, 16'h002E, 0, 16'h000A, 5'h10, 16'h401F);
        txc(8'h44, 16'h0040, 16'h002E, 16'h002E, 0, 0, 0, 16'h4040);
        txc(8'h46, 16'h0040, 16'h002E, 16'h002E, 0, 0, 0, 16'hFFFF);
        txc(8'h41, 16'h0040, 16'h002E, 16'h002E, 0, 16'h000A, 5'h02, 16'hFFFF);
        axw(`EID_OFS_CTRL, 32'h0000_0003);
        repeat (2) @(posedge aclk);
        chk("txrst", n_rst, 1);
        complete_run;
    end
endmodule
